// *** osr_pkg.sv ***
// Package with the constants of the operation status register block
package osr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Word layout
  localparam int unsigned     OSR_WORD_W    = 16;   // Status word width
  localparam int unsigned     OSR_WR_W      = 32;   // Width of a written value
  localparam int unsigned     OSR_IRQ_N     = 7;    // Interrupt request lines

  // Operation status word bit positions
  localparam int unsigned     OSR_BIT_CAL   = 0;    // Calibration in progress
  localparam int unsigned     OSR_BIT_TRIG  = 5;    // Trigger activity
  localparam int unsigned     OSR_BIT_MON   = 8;    // Monitor
  localparam int unsigned     OSR_BIT_PWRDN = 9;    // Mainframe power-down
  localparam int unsigned     OSR_BIT_IRQ   = 10;   // Bus interrupt summary

  // Used-bit masks of each word
  localparam logic [15:0]     OSR_OP_USED   = 16'h0721;
  localparam logic [15:0]     OSR_IRQ_USED  = 16'h007f;

  // Reset values
  localparam logic [15:0]     OSR_RST_WORD  = 16'h0000;
  localparam logic [15:0]     OSR_PRESET    = 16'h0000;

  // Largest legal mask value
  localparam logic [31:0]     OSR_MASK_MAX  = 32'h0000ffff;

  // Data-out-of-range error code (two's complement of 222)
  localparam logic [15:0]     OSR_ERR_RANGE = 16'hff22;
  localparam logic [15:0]     OSR_ERR_NONE  = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Register selectors of the query and write ports
  typedef enum logic [2:0] {
    OSR_SEL_OP_EVENT  = 3'h0,  // Operation event latch
    OSR_SEL_OP_COND   = 3'h1,  // Operation live state
    OSR_SEL_OP_MASK   = 3'h2,  // Operation event mask
    OSR_SEL_IRQ_EVENT = 3'h3,  // Bus interrupt event latch
    OSR_SEL_IRQ_COND  = 3'h4,  // Bus interrupt line state
    OSR_SEL_IRQ_MASK  = 3'h5   // Bus interrupt event mask
  } osr_sel_t;

  // Start-up sequencer states, one-hot
  typedef enum logic [1:0] {
    OSR_ST_BOOT = 2'h1,  // Mask reload pending
    OSR_ST_RUN  = 2'h2   // Normal operation
  } osr_state_t;

endpackage

// *** osr_latch_if.sv ***
// Interface joining a status group to its edge-latched event register
`timescale 1ns/10ps
interface osr_latch_if #(
  parameter int unsigned W = 16
);
  logic [W-1:0] cond;     // Live condition bits
  logic         clear;    // Clear the whole event word
  logic [W-1:0] event_q;  // Latched event bits

  // Owner of the status group
  modport group (output cond, output clear, input event_q);
  // Edge latch itself
  modport latch (input cond, input clear, output event_q);
endinterface

// *** osr_edge_latch.sv ***
// Rising-edge event latch with clear, one bit per condition
`timescale 1ns/10ps
module osr_edge_latch #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input  wire logic  i_mclk,
  input  wire logic  i_resetn,
  // Condition and event word
  osr_latch_if.latch bus
);
  import osr_pkg::*;

  logic [W-1:0] prev;   // Condition seen last cycle
  logic [W-1:0] rise;   // False-to-true transitions
  logic [W-1:0] next_event;

  // A new edge survives a clear in the same cycle
  assign rise       = bus.cond & ~prev;
  assign next_event = (bus.clear ? '0 : bus.event_q) | rise;

  // Previous condition and held events
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev        <= '0;
      bus.event_q <= '0;
    end else begin
      prev        <= bus.cond;
      bus.event_q <= next_event;
    end
  end
endmodule

// *** osr_status_regs.sv ***
// Operation status and bus-interrupt monitor register groups
// Summary of operation
// - Operation event bit sets on condition rise
// - Fixed operation word bit positions
// - Unused operation event bits read zero
// - Operation event clears on read or clear-status
// - Condition bits track live state
// - Condition read non-destructive, unused bits zero
// - Unused mask bits accepted and ignored
// - Power-on operation mask from storage unless flag
// - Status preset zeroes the masks, except the operation mask in the boot cycle
// - Mask above 16 bits rejected, code -222 except in the boot cycle
// - Interrupt line rises latch into bits 0-6
// - Interrupt events clear on read or clear-status
// - Captured line state returned by condition query
// - Monitor init clears captured line state
// - Query returns whole word as unsigned
// - Mask only gates events into summary
// - Event holds until read or clear
`timescale 1ns/10ps
module osr_status_regs (
  // Clock and reset
  input  wire logic                         i_mclk,
  input  wire logic                         i_resetn,
  // Live operation conditions
  input  wire logic                         i_calibration_in_progress,
  input  wire logic                         i_trigger_active,
  input  wire logic                         i_monitor_active,
  input  wire logic                         i_power_down,
  // Bus interrupt monitor
  input  wire logic [osr_pkg::OSR_IRQ_N-1:0] i_irq_lines,
  input  wire logic                         i_monitor_init,
  // Commands
  input  wire logic                         i_clear_status_command,
  input  wire logic                         i_status_preset,
  // Power-on mask source
  input  wire logic                         i_power_on_status_clear_flag,
  input  wire logic [osr_pkg::OSR_WORD_W-1:0] i_nv_mask,
  // Query port
  input  wire logic                         i_query_valid,
  input  wire osr_pkg::osr_sel_t            i_query_sel,
  output      logic                         o_resp_valid,
  output      logic [osr_pkg::OSR_WORD_W-1:0] o_resp_data,
  // Mask write port
  input  wire logic                         i_wr_valid,
  input  wire osr_pkg::osr_sel_t            i_wr_sel,
  input  wire logic [osr_pkg::OSR_WR_W-1:0] i_wr_data,
  output      logic                         o_err_valid,
  output      logic [osr_pkg::OSR_WORD_W-1:0] o_err_code,
  // Summary to the parent status register
  output      logic                         o_operation_summary
);
  import osr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  osr_latch_if #(.W(OSR_WORD_W)) op_lif ();   // Operation event latch
  osr_latch_if #(.W(OSR_WORD_W)) irq_lif ();  // Bus interrupt event latch

  osr_state_t              state;          // Start-up sequencer
  osr_state_t              next_state;
  logic [OSR_WORD_W-1:0]   op_mask;        // Operation event mask
  logic [OSR_WORD_W-1:0]   irq_mask;       // Bus interrupt event mask
  logic [OSR_IRQ_N-1:0]    line_capture;   // Captured interrupt lines
  logic [OSR_WORD_W-1:0]   op_cond;        // Operation live word
  logic [OSR_WORD_W-1:0]   irq_cond;       // Line state word
  logic [OSR_WORD_W-1:0]   op_event;       // Operation events, used bits
  logic [OSR_WORD_W-1:0]   irq_event;      // Interrupt events, used bits
  logic [OSR_WORD_W-1:0]   irq_line_word;  // Raw lines placed in a word
  logic                    irq_summary;    // Masked interrupt summary
  logic                    rd_op_event;    // Query reads operation events
  logic                    rd_irq_event;   // Query reads interrupt events
  logic                    wr_ok;          // Write in range
  logic                    wr_bad;         // Write out of range
  logic                    wr_op;          // Legal write to operation mask
  logic                    wr_irq;         // Legal write to interrupt mask
  logic                    boot;           // Reload cycle after reset
  logic [OSR_WORD_W-1:0]   boot_mask;      // Mask chosen at power-on
  logic [OSR_WORD_W-1:0]   wr_word;        // Written value, low 16 bits
  logic [OSR_WORD_W-1:0]   rd_mux;         // Selected query word
  logic [OSR_WORD_W-1:0]   next_op_mask;
  logic [OSR_WORD_W-1:0]   next_irq_mask;
  logic [OSR_IRQ_N-1:0]    next_capture;

  ////////////////////////////////////////////////////////////////////////////
  // Operation status word
  // Condition word built from live inputs and the interrupt summary, unused positions tied low
  assign irq_summary = |(irq_event & irq_mask);
  always_comb begin
    op_cond                = OSR_RST_WORD;
    op_cond[OSR_BIT_CAL]   = i_calibration_in_progress;
    op_cond[OSR_BIT_TRIG]  = i_trigger_active;
    op_cond[OSR_BIT_MON]   = i_monitor_active;
    op_cond[OSR_BIT_PWRDN] = i_power_down;
    op_cond[OSR_BIT_IRQ]   = irq_summary;
  end

  // Event latch watches the condition word
  assign op_lif.cond  = op_cond;
  assign rd_op_event  = i_query_valid && (i_query_sel == OSR_SEL_OP_EVENT);
  assign op_lif.clear = rd_op_event | i_clear_status_command;
  assign op_event     = op_lif.event_q & OSR_OP_USED;

  osr_edge_latch #(.W(OSR_WORD_W)) u_op_latch (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .bus      (op_lif.latch)
  );

  // Mask only gates events, it never touches them
  assign o_operation_summary = |(op_event & op_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Bus interrupt monitor
  // Raw lines in the low bits of a word
  assign irq_line_word = {{(OSR_WORD_W - OSR_IRQ_N){1'b0}}, i_irq_lines};
  assign irq_lif.cond  = irq_line_word;
  assign rd_irq_event  = i_query_valid && (i_query_sel == OSR_SEL_IRQ_EVENT);
  assign irq_lif.clear = rd_irq_event | i_clear_status_command;
  assign irq_event     = irq_lif.event_q & OSR_IRQ_USED;

  osr_edge_latch #(.W(OSR_WORD_W)) u_irq_latch (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .bus      (irq_lif.latch)
  );

  // Lines are caught and held until the monitor is initialised
  assign next_capture = i_monitor_init ? '0 : (line_capture | i_irq_lines);
  assign irq_cond     = {{(OSR_WORD_W - OSR_IRQ_N){1'b0}}, line_capture};

  // Captured line register
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      line_capture <= '0;
    end else begin
      line_capture <= next_capture;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start-up sequencer
  // One reload cycle after reset release, then run
  always_comb begin
    case (state)
      OSR_ST_BOOT: next_state = OSR_ST_RUN;
      OSR_ST_RUN:  next_state = OSR_ST_RUN;
      default:     next_state = OSR_ST_BOOT;
    endcase
  end

  // State register
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= OSR_ST_BOOT;
    end else begin
      state <= next_state;
    end
  end

  assign boot      = (state == OSR_ST_BOOT);
  // Stored mask unless the clear flag is set
  assign boot_mask = i_power_on_status_clear_flag ? OSR_PRESET
                                                  : (i_nv_mask & OSR_OP_USED);

  ////////////////////////////////////////////////////////////////////////////
  // Mask writes
  // Range check, then unused bits dropped
  assign wr_ok   = (i_wr_data <= OSR_MASK_MAX);
  assign wr_bad  = i_wr_valid && !wr_ok && !boot;
  assign wr_op   = i_wr_valid && wr_ok && (i_wr_sel == OSR_SEL_OP_MASK);
  assign wr_irq  = i_wr_valid && wr_ok && (i_wr_sel == OSR_SEL_IRQ_MASK);
  assign wr_word = i_wr_data[OSR_WORD_W-1:0];

  // Operation mask next value: boot, then preset, then write
  always_comb begin
    if (boot) begin
      next_op_mask = boot_mask;
    end else if (i_status_preset) begin
      next_op_mask = OSR_PRESET;
    end else if (wr_op) begin
      next_op_mask = wr_word & OSR_OP_USED;
    end else begin
      next_op_mask = op_mask;
    end
  end

  // Interrupt mask next value
  always_comb begin
    if (boot || i_status_preset) begin
      next_irq_mask = OSR_PRESET;
    end else if (wr_irq) begin
      next_irq_mask = wr_word & OSR_IRQ_USED;
    end else begin
      next_irq_mask = irq_mask;
    end
  end

  // Mask registers
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      op_mask  <= OSR_RST_WORD;
      irq_mask <= OSR_RST_WORD;
    end else begin
      op_mask  <= next_op_mask;
      irq_mask <= next_irq_mask;
    end
  end

  // Error report, one cycle after the bad write
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_err_valid <= 1'b0;
      o_err_code  <= OSR_ERR_NONE;
    end else begin
      o_err_valid <= wr_bad;
      o_err_code  <= wr_bad ? OSR_ERR_RANGE : OSR_ERR_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Query response
  // Selected word, returned whole and unsigned
  always_comb begin
    case (i_query_sel)
      OSR_SEL_OP_EVENT:  rd_mux = op_event;
      OSR_SEL_OP_COND:   rd_mux = op_cond;
      OSR_SEL_OP_MASK:   rd_mux = op_mask;
      OSR_SEL_IRQ_EVENT: rd_mux = irq_event;
      OSR_SEL_IRQ_COND:  rd_mux = irq_cond;
      OSR_SEL_IRQ_MASK:  rd_mux = irq_mask;
      default:           rd_mux = OSR_RST_WORD;
    endcase
  end

  // Response registers
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_resp_valid <= 1'b0;
      o_resp_data  <= OSR_RST_WORD;
    end else begin
      o_resp_valid <= i_query_valid;
      o_resp_data  <= i_query_valid ? rd_mux : o_resp_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_rise_sets;
    @(posedge i_mclk) disable iff (!i_resetn)
    (state == OSR_ST_RUN) && i_trigger_active && !$past(i_trigger_active)
      |=> op_event[OSR_BIT_TRIG];
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("Trigger rise did not set its event bit");

  property p_unused_zero;
    @(posedge i_mclk) disable iff (!i_resetn)
    (op_event & ~OSR_OP_USED) == OSR_RST_WORD;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("Unused operation event bit is set");

  property p_read_clears;
    @(posedge i_mclk) disable iff (!i_resetn)
    rd_op_event && (op_cond == $past(op_cond))
      |=> o_resp_valid && (o_resp_data == $past(op_event))
          && ((op_event & ~(op_cond & ~$past(op_cond))) == OSR_RST_WORD);
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("Event read did not return and clear the word");

  property p_cond_track;
    @(posedge i_mclk) disable iff (!i_resetn)
    i_query_valid && (i_query_sel == OSR_SEL_OP_COND)
      |=> o_resp_data[OSR_BIT_MON] == $past(i_monitor_active)
          && (o_resp_data & ~OSR_OP_USED) == OSR_RST_WORD;
  endproperty
  a_cond_track: assert property (p_cond_track)
    else $error("Condition query does not show the live state");

  property p_range;
    @(posedge i_mclk) disable iff (!i_resetn)
    wr_bad |=> o_err_valid && (o_err_code == OSR_ERR_RANGE)
               && (op_mask == $past(op_mask) || $past(i_status_preset));
  endproperty
  a_range: assert property (p_range)
    else $error("Out-of-range mask write was not refused");

  property p_preset;
    @(posedge i_mclk) disable iff (!i_resetn)
    i_status_preset |=> op_mask == OSR_PRESET;
  endproperty
  a_preset: assert property (p_preset)
    else $error("Status preset did not zero the mask");

  property p_boot_mask;
    @(posedge i_mclk) disable iff (!i_resetn)
    boot && !i_power_on_status_clear_flag
      |=> op_mask == ($past(i_nv_mask) & OSR_OP_USED);
  endproperty
  a_boot_mask: assert property (p_boot_mask)
    else $error("Power-on mask was not reloaded from storage");

  property p_event_hold;
    @(posedge i_mclk) disable iff (!i_resetn)
    op_event[OSR_BIT_CAL] && !op_lif.clear |=> op_event[OSR_BIT_CAL];
  endproperty
  a_event_hold: assert property (p_event_hold)
    else $error("Event bit dropped without a read or clear");

  property p_init_clears;
    @(posedge i_mclk) disable iff (!i_resetn)
    i_monitor_init |=> irq_cond == OSR_RST_WORD;
  endproperty
  a_init_clears: assert property (p_init_clears)
    else $error("Monitor init left captured lines set");

  // A fresh masked interrupt event must land in operation bit ten
  property p_irq_summary;
    @(posedge i_mclk) disable iff (!i_resetn)
    (state == OSR_ST_RUN) && |(irq_event & irq_mask)
      && !(|($past(irq_event) & $past(irq_mask)))
      |=> op_event[OSR_BIT_IRQ];
  endproperty
  a_irq_summary: assert property (p_irq_summary)
    else $error("Masked interrupt event did not reach operation bit ten");

  // Interrupt event read returns the word and leaves it empty
  property p_irq_read_clears;
    @(posedge i_mclk) disable iff (!i_resetn)
    (state == OSR_ST_RUN) && rd_irq_event && (irq_line_word == $past(irq_line_word))
      |=> (o_resp_data == $past(irq_event)) && (irq_event == OSR_RST_WORD);
  endproperty
  a_irq_read_clears: assert property (p_irq_read_clears)
    else $error("Interrupt event read did not return and clear the word");

  c_bad_write: cover property (@(posedge i_mclk) disable iff (!i_resetn) wr_bad);
  c_irq_event: cover property (@(posedge i_mclk) disable iff (!i_resetn)
    rd_irq_event && (irq_event != OSR_RST_WORD));
  c_summary:   cover property (@(posedge i_mclk) disable iff (!i_resetn)
    o_operation_summary);
  c_preset:    cover property (@(posedge i_mclk) disable iff (!i_resetn)
    i_status_preset && (op_mask != OSR_RST_WORD));
endmodule

// *** test_osr_status_regs.sv ***
// Self-checking testbench of the operation status register block
`timescale 1ns/10ps
module test_osr_status_regs;
  import osr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed outputs
  logic        i_mclk;                        // 200 MHz clock
  logic        i_resetn;                      // Async reset, active low
  logic        i_calibration_in_progress;     // Live condition, bit 0
  logic        i_trigger_active;              // Live condition, bit 5
  logic        i_monitor_active;              // Live condition, bit 8
  logic        i_power_down;                  // Live condition, bit 9
  logic [6:0]  i_irq_lines;                   // Interrupt request lines
  logic        i_monitor_init;                // Monitor init pulse
  logic        i_clear_status_command;        // Clear-status pulse
  logic        i_status_preset;               // Status preset pulse
  logic        i_power_on_status_clear_flag;  // Power-on clear flag
  logic [15:0] i_nv_mask;                     // Stored mask
  logic        i_query_valid;                 // Query strobe
  osr_sel_t    i_query_sel;                   // Query selector
  logic        o_resp_valid;                  // Answer strobe
  logic [15:0] o_resp_data;                   // Answer word
  logic        i_wr_valid;                    // Write strobe
  osr_sel_t    i_wr_sel;                      // Write selector
  logic [31:0] i_wr_data;                     // Written value
  logic        o_err_valid;                   // Error strobe
  logic [15:0] o_err_code;                    // Error code
  logic        o_operation_summary;           // Summary bit
  int          bad_count;                     // Mismatches
  int          cmp_count;                     // Comparisons
  int unsigned cbit [4] = '{OSR_BIT_CAL, OSR_BIT_TRIG, OSR_BIT_MON, OSR_BIT_PWRDN};

  ////////////////////////////////////////////////////////////////////////////
  // Design under test
  osr_status_regs uut (
    .i_mclk                       (i_mclk),
    .i_resetn                     (i_resetn),
    .i_calibration_in_progress    (i_calibration_in_progress),
    .i_trigger_active             (i_trigger_active),
    .i_monitor_active             (i_monitor_active),
    .i_power_down                 (i_power_down),
    .i_irq_lines                  (i_irq_lines),
    .i_monitor_init               (i_monitor_init),
    .i_clear_status_command       (i_clear_status_command),
    .i_status_preset              (i_status_preset),
    .i_power_on_status_clear_flag (i_power_on_status_clear_flag),
    .i_nv_mask                    (i_nv_mask),
    .i_query_valid                (i_query_valid),
    .i_query_sel                  (i_query_sel),
    .o_resp_valid                 (o_resp_valid),
    .o_resp_data                  (o_resp_data),
    .i_wr_valid                   (i_wr_valid),
    .i_wr_sel                     (i_wr_sel),
    .i_wr_data                    (i_wr_data),
    .o_err_valid                  (o_err_valid),
    .o_err_code                   (o_err_code),
    .o_operation_summary          (o_operation_summary)
  );

  // Free-running clock, 5 ns period
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  // Compare one value and count it
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // Reset with a chosen power-on flag and stored mask
  task automatic do_reset(input logic flag, input logic [15:0] nv);
    @(posedge i_mclk);
    i_resetn                     <= 1'b0;
    i_power_on_status_clear_flag <= flag;
    i_nv_mask                    <= nv;
    repeat (8) @(posedge i_mclk);
    chk("resp_valid in reset", o_resp_valid, 1'b0);
    chk("err_valid in reset", o_err_valid, 1'b0);
    i_resetn <= 1'b1;
    // Boot cycle, then one more before any write
    repeat (2) @(posedge i_mclk);
  endtask

  // One query; the answer stands 1 ns after the taking edge
  task automatic query(input osr_sel_t sel, input logic [15:0] exp, input string name);
    @(posedge i_mclk);
    i_query_valid <= 1'b1;
    i_query_sel   <= sel;
    @(posedge i_mclk);
    i_query_valid <= 1'b0;
    #1;
    chk("resp_valid", o_resp_valid, 1'b1);
    chk(name, o_resp_data, exp);
  endtask

  // One mask write; an error answer stands 1 ns after the taking edge
  task automatic write(input osr_sel_t sel, input logic [31:0] data, input logic err);
    @(posedge i_mclk);
    i_wr_valid <= 1'b1;
    i_wr_sel   <= sel;
    i_wr_data  <= data;
    @(posedge i_mclk);
    i_wr_valid <= 1'b0;
    #1;
    chk("err_valid", o_err_valid, err);
    chk("err_code", o_err_code, err ? OSR_ERR_RANGE : OSR_ERR_NONE);
  endtask

  // Drive one live condition
  task automatic drive_cond(input int idx, input logic v);
    @(posedge i_mclk);
    case (idx)
      0: i_calibration_in_progress <= v;
      1: i_trigger_active          <= v;
      2: i_monitor_active          <= v;
      default: i_power_down        <= v;
    endcase
  endtask

  // Drive the interrupt lines
  task automatic set_lines(input logic [6:0] v);
    @(posedge i_mclk);
    i_irq_lines <= v;
  endtask

  // One-cycle command pulse: 0 clear-status, 1 preset, 2 monitor init
  task automatic pulse(input int which);
    @(posedge i_mclk);
    case (which)
      0: i_clear_status_command <= 1'b1;
      1: i_status_preset        <= 1'b1;
      default: i_monitor_init   <= 1'b1;
    endcase
    @(posedge i_mclk);
    i_clear_status_command <= 1'b0;
    i_status_preset        <= 1'b0;
    i_monitor_init         <= 1'b0;
    repeat (2) @(posedge i_mclk);
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    bad_count = 0;
    cmp_count = 0;
    i_resetn = 1'b0;
    {i_calibration_in_progress, i_trigger_active, i_monitor_active, i_power_down} = 4'h0;
    i_irq_lines = 7'h00;
    {i_monitor_init, i_clear_status_command, i_status_preset} = 3'h0;
    i_power_on_status_clear_flag = 1'b0;
    i_nv_mask = 16'h0000;
    i_query_valid = 1'b0;
    i_query_sel = OSR_SEL_OP_EVENT;
    i_wr_valid = 1'b0;
    i_wr_sel = OSR_SEL_OP_MASK;
    i_wr_data = 32'h0;
    // Power-on mask from storage, then with the clear flag set
    do_reset(1'b0, 16'hffff);
    query(OSR_SEL_OP_MASK, OSR_OP_USED, "op_mask");
    query(OSR_SEL_OP_EVENT, 16'h0000, "op_event");
    query(OSR_SEL_OP_COND, 16'h0000, "op_cond");
    do_reset(1'b1, 16'hffff);
    query(OSR_SEL_OP_MASK, 16'h0000, "op_mask");
    // Each condition at its bit, read twice each way
    for (int i = 0; i < 4; i++) begin
      drive_cond(i, 1'b1);
      repeat (2) @(posedge i_mclk);
      query(OSR_SEL_OP_COND, 16'h1 << cbit[i], "op_cond");
      query(OSR_SEL_OP_COND, 16'h1 << cbit[i], "op_cond");
      query(OSR_SEL_OP_EVENT, 16'h1 << cbit[i], "op_event");
      query(OSR_SEL_OP_EVENT, 16'h0000, "op_event");
      drive_cond(i, 1'b0);
      repeat (2) @(posedge i_mclk);
      query(OSR_SEL_OP_COND, 16'h0000, "op_cond");
      query(OSR_SEL_OP_EVENT, 16'h0000, "op_event");
    end
    // Event outlives its condition; clear-status empties it
    drive_cond(0, 1'b1);
    drive_cond(0, 1'b0);
    repeat (2) @(posedge i_mclk);
    query(OSR_SEL_OP_EVENT, 16'h0001, "op_event");
    drive_cond(0, 1'b1);
    pulse(0);
    query(OSR_SEL_OP_EVENT, 16'h0000, "op_event");
    drive_cond(0, 1'b0);
    // Mask range, unused bits, preset
    write(OSR_SEL_OP_MASK, 32'h00000100, 1'b0);
    query(OSR_SEL_OP_MASK, 16'h0100, "op_mask");
    write(OSR_SEL_OP_MASK, 32'h0000ffff, 1'b0);
    query(OSR_SEL_OP_MASK, OSR_OP_USED, "op_mask");
    write(OSR_SEL_OP_MASK, 32'h00010000, 1'b1);
    query(OSR_SEL_OP_MASK, OSR_OP_USED, "op_mask");
    write(OSR_SEL_OP_EVENT, 32'h00000001, 1'b0);
    query(OSR_SEL_OP_EVENT, 16'h0000, "op_event");
    pulse(1);
    query(OSR_SEL_OP_MASK, 16'h0000, "op_mask");
    // Mask gates only the summary
    write(OSR_SEL_OP_MASK, 32'h00000020, 1'b0);
    drive_cond(1, 1'b1);
    repeat (3) @(posedge i_mclk);
    #1;
    chk("summary", o_operation_summary, 1'b1);
    write(OSR_SEL_OP_MASK, 32'h00000001, 1'b0);
    chk("summary", o_operation_summary, 1'b0);
    query(OSR_SEL_OP_EVENT, 16'h0020, "op_event");
    drive_cond(1, 1'b0);
    // Interrupt summary at bit 10 through its own mask
    write(OSR_SEL_OP_MASK, 32'h00000400, 1'b0);
    write(OSR_SEL_IRQ_MASK, 32'h0000007b, 1'b0);
    set_lines(7'h04);
    repeat (5) @(posedge i_mclk);
    query(OSR_SEL_OP_COND, 16'h0000, "op_cond");
    write(OSR_SEL_IRQ_MASK, 32'h0000007f, 1'b0);
    query(OSR_SEL_IRQ_MASK, 16'h007f, "irq_mask");
    repeat (4) @(posedge i_mclk);
    #1;
    chk("summary", o_operation_summary, 1'b1);
    query(OSR_SEL_OP_COND, 16'h0400, "op_cond");
    query(OSR_SEL_IRQ_COND, 16'h0004, "irq_cond");
    query(OSR_SEL_IRQ_EVENT, 16'h0004, "irq_event");
    query(OSR_SEL_IRQ_EVENT, 16'h0000, "irq_event");
    query(OSR_SEL_OP_EVENT, 16'h0400, "op_event");
    set_lines(7'h00);
    // Every line latches into its bit; captured state stays sticky
    pulse(2);
    query(OSR_SEL_IRQ_COND, 16'h0000, "irq_cond");
    for (int i = 0; i < 7; i++) begin
      set_lines(7'h01 << i);
      set_lines(7'h00);
      repeat (2) @(posedge i_mclk);
      query(OSR_SEL_IRQ_EVENT, 16'h1 << i, "irq_event");
    end
    query(OSR_SEL_IRQ_COND, OSR_IRQ_USED, "irq_cond");
    set_lines(7'h01);
    pulse(0);
    query(OSR_SEL_IRQ_EVENT, 16'h0000, "irq_event");
    set_lines(7'h00);
    pulse(2);
    query(OSR_SEL_IRQ_COND, 16'h0000, "irq_cond");
    wrap_up();
  end
endmodule
